// ---- include/mcsd_div_if.sv ----
// mcsd_div_if: enable and tick between top and divider
// assumes both ends on ref_clk
`timescale 1ns/1ps

interface mcsd_div_if;
	logic tick_in;
	logic phase;
	logic tick_out;

	modport ctl (output tick_in, input phase, input tick_out);
	modport div (input tick_in, output phase, output tick_out);
endinterface : mcsd_div_if

// ---- include/mcsd_params.svh ----
// mcsd_params.svh: constants of the main clock select and divider
// assumes a single 40 MHz ref_clk domain for all control logic
`ifndef MCSD_PARAMS_SVH
`define MCSD_PARAMS_SVH

`define MCSD_CLK_PERIOD_NS     25
`define MCSD_MAIN_OSC_KHZ      8192
`define MCSD_SRC_RESET         1'b0
`define MCSD_DIV_RESET         1'b0
`define MCSD_SECTIONS          2
`define MCSD_CONVERTERS        3
`define MCSD_DIAG_DIV          4

`endif

// ---- include/mcsd_pkg.sv ----
// mcsd_pkg: types of the main clock select and divider
// assumes the constants header is included by the users
package mcsd_pkg;

	typedef enum logic {
		MCSD_SRC_INTERNAL,
		MCSD_SRC_EXTERNAL
	} mcsd_src_t;

endpackage : mcsd_pkg

// ---- rtl/mcsd_div2.sv ----
// mcsd_div2: divide-by-two toggle stage on enable pulses
// assumes tick_in is a one-cycle enable on ref_clk
`timescale 1ns/1ps
`include "mcsd_params.svh"

module mcsd_div2 (
	input  wire logic ref_clk,
	input  wire logic rst,
	mcsd_div_if.div   dif
);
	import mcsd_pkg::*;

	logic phase_q;

	// toggle on each main tick gives 50% duty at half rate
	always_ff @(posedge ref_clk) begin
		if (rst)
			phase_q <= `MCSD_DIV_RESET;
		else if (dif.tick_in)
			phase_q <= ~phase_q;
	end

	assign dif.phase    = phase_q;
	assign dif.tick_out = dif.tick_in & phase_q;

	phase_align_a: assert property (@(posedge ref_clk)
		rst |=> phase_q == 1'h0)
		else $error("divider phase not cleared by reset");
	half_rate_a: assert property (@(posedge ref_clk)
		disable iff (rst)
		dif.tick_in |=> phase_q != $past(phase_q))
		else $error("divider missed a toggle");
	hold_a: assert property (@(posedge ref_clk)
		disable iff (rst)
		!dif.tick_in |=> $stable(phase_q))
		else $error("divider toggled without tick");
endmodule : mcsd_div2

// ---- rtl/mcsd_top.sv ----
// mcsd_top: main clock source select and modulator clock generation
// assumes oscillator edges arrive as pins, sampled here at 40 MHz
`timescale 1ns/1ps
`include "mcsd_params.svh"

// Functional notes
// - main clock from oscillator or external pin
// - reset selects internal main oscillator
// - modulator clock is main clock halved
// - all converters share one modulator clock
// - both sections use same main clock
// - separate diagnostic oscillator clocks monitors
module mcsd_top #(
	parameter int SECTIONS   = `MCSD_SECTIONS,
	parameter int CONVERTERS = `MCSD_CONVERTERS
) (
	input  wire logic                   ref_clk,
	input  wire logic                   rst,
	input  wire logic                   src_sel,
	input  wire logic                   main_oscillator,
	input  wire logic                   ext_clk,
	input  wire logic                   diagnostic_oscillator,
	output mcsd_pkg::mcsd_src_t         src_active,
	output logic                        main_tick,
	output logic [SECTIONS-1:0]         section_tick,
	output logic [CONVERTERS-1:0]       modulator_frequency,
	output logic                        modulator_tick,
	output logic                        diag_tick,
	output logic                        switch_busy
);
	import mcsd_pkg::*;

	logic [1:0] osc_s_q;
	logic [1:0] ext_s_q;
	logic [1:0] dgo_s_q;
	logic       osc_d_q;
	logic       ext_d_q;
	logic       dgo_d_q;
	mcsd_src_t  src_q;
	logic       busy_q;
	logic       tick_q;
	logic       dtick_q;

	// two-flop synchronisers; only stage two feeds edge detection
	always_ff @(posedge ref_clk) begin
		osc_s_q <= {osc_s_q[0], main_oscillator};
		ext_s_q <= {ext_s_q[0], ext_clk};
		dgo_s_q <= {dgo_s_q[0], diagnostic_oscillator};
		osc_d_q <= osc_s_q[1];
		ext_d_q <= ext_s_q[1];
		dgo_d_q <= dgo_s_q[1];
	end

	wire osc_rise = osc_s_q[1] & ~osc_d_q;
	wire ext_rise = ext_s_q[1] & ~ext_d_q;
	wire dgo_rise = dgo_s_q[1] & ~dgo_d_q;
	wire want_ext = src_sel;
	wire cur_ext  = (src_q == MCSD_SRC_EXTERNAL);
	wire change   = (want_ext != cur_ext);
	// switch only on an edge of the incoming source, so the new clock
	// must be running by then; the host gates converters meanwhile
	wire new_edge = want_ext ? ext_rise : osc_rise;
	wire sel_rise = cur_ext ? ext_rise : osc_rise;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			src_q  <= MCSD_SRC_INTERNAL;
			busy_q <= 1'h0;
		end else begin
			busy_q <= change & ~new_edge;
			if (change && new_edge)
				src_q <= want_ext ? MCSD_SRC_EXTERNAL
				                  : MCSD_SRC_INTERNAL;
		end
	end

	// no ticks during a pending switch avoids a runt modulator edge
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			tick_q  <= 1'h0;
			dtick_q <= 1'h0;
		end else begin
			tick_q  <= sel_rise & ~change;
			dtick_q <= dgo_rise;
		end
	end

	mcsd_div_if dif ();
	assign dif.tick_in = tick_q;

	mcsd_div2 u_div (
		.ref_clk (ref_clk),
		.rst     (rst),
		.dif     (dif)
	);

	assign src_active          = src_q;
	assign main_tick           = tick_q;
	genvar sec_i;
	genvar conv_i;
	// one copy per section keeps both on the same main tick
	for (sec_i = 0; sec_i < SECTIONS; sec_i = sec_i + 1) begin : g_section
		assign section_tick[sec_i] = tick_q;
	end
	// converters get no private clock, only this shared phase
	for (conv_i = 0; conv_i < CONVERTERS; conv_i = conv_i + 1) begin : g_conv
		assign modulator_frequency[conv_i] = dif.phase;
	end
	assign modulator_tick      = dif.tick_out;
	assign diag_tick           = dtick_q;
	assign switch_busy         = busy_q;

	reset_internal_a: assert property (@(posedge ref_clk)
		rst |=> src_q == MCSD_SRC_INTERNAL)
		else $error("reset did not pick internal oscillator");
	switch_edge_a: assert property (@(posedge ref_clk)
		disable iff (rst)
		(src_q != $past(src_q)) |-> $past(change && new_edge))
		else $error("source changed off an edge");
	no_tick_switch_a: assert property (@(posedge ref_clk)
		disable iff (rst)
		$past(change) |-> !tick_q)
		else $error("main tick during switchover");
	shared_mod_a: assert property (@(posedge ref_clk)
		disable iff (rst)
		modulator_frequency == {CONVERTERS{modulator_frequency[0]}})
		else $error("converter modulator clocks differ");
	sections_a: assert property (@(posedge ref_clk)
		disable iff (rst)
		section_tick == {SECTIONS{main_tick}})
		else $error("section clocks differ");
	diag_path_a: assert property (@(posedge ref_clk)
		disable iff (rst)
		dgo_rise |=> diag_tick)
		else $error("diagnostic tick missing");
	mod_half_a: assert property (@(posedge ref_clk)
		disable iff (rst)
		modulator_tick |-> main_tick && modulator_frequency[0])
		else $error("modulator tick not on odd main tick");
	busy_a: assert property (@(posedge ref_clk)
		disable iff (rst)
		$past(change) && !$past(new_edge) |-> switch_busy)
		else $error("busy flag not shown");

	// switchover steps: request, wait for the new edge, settle
	sequence ext_request_s;
		want_ext && !cur_ext;
	endsequence
	sequence int_request_s;
		!want_ext && cur_ext;
	endsequence
	sequence ext_edge_s;
		ext_request_s ##0 ext_rise;
	endsequence
	sequence int_edge_s;
		int_request_s ##0 osc_rise;
	endsequence
	sequence pending_s;
		change && !new_edge;
	endsequence
	sequence settle_s;
		change && new_edge;
	endsequence
	sequence tick_cause_s;
		sel_rise && !change;
	endsequence
	sequence odd_tick_s;
		main_tick && modulator_frequency[0];
	endsequence
	sequence even_tick_s;
		main_tick && !modulator_frequency[0];
	endsequence

	to_ext_a: assert property (@(posedge ref_clk)
		disable iff (rst)
		ext_edge_s |=> src_q == MCSD_SRC_EXTERNAL)
		else $error("switch to external clock missed");
	to_int_a: assert property (@(posedge ref_clk)
		disable iff (rst)
		int_edge_s |=> src_q == MCSD_SRC_INTERNAL)
		else $error("switch to internal oscillator missed");
	src_hold_a: assert property (@(posedge ref_clk)
		disable iff (rst)
		!change |=> $stable(src_q))
		else $error("source moved without a request");
	pending_a: assert property (@(posedge ref_clk)
		disable iff (rst)
		pending_s |=> switch_busy && $stable(src_q))
		else $error("pending switch not held");
	settle_a: assert property (@(posedge ref_clk)
		disable iff (rst)
		settle_s |=> !switch_busy)
		else $error("busy flag stuck after switch");
	idle_busy_a: assert property (@(posedge ref_clk)
		disable iff (rst)
		!$past(change) |-> !switch_busy)
		else $error("busy flag without a request");
	tick_cause_a: assert property (@(posedge ref_clk)
		disable iff (rst)
		tick_cause_s |=> main_tick)
		else $error("main tick lost");
	tick_source_a: assert property (@(posedge ref_clk)
		disable iff (rst)
		main_tick |-> $past(sel_rise) && !$past(change))
		else $error("main tick without source edge");
	reset_quiet_a: assert property (@(posedge ref_clk)
		rst |=> !main_tick && !switch_busy && !diag_tick)
		else $error("outputs active after reset");
	reset_phase_a: assert property (@(posedge ref_clk)
		rst |=> modulator_frequency == '0)
		else $error("modulator phase not aligned by reset");
	mod_fall_a: assert property (@(posedge ref_clk)
		disable iff (rst)
		odd_tick_s |=> !modulator_frequency[0])
		else $error("modulator clock did not fall");
	mod_rise_a: assert property (@(posedge ref_clk)
		disable iff (rst)
		even_tick_s |=> modulator_frequency[0])
		else $error("modulator clock did not rise");
	diag_cause_a: assert property (@(posedge ref_clk)
		disable iff (rst)
		diag_tick |-> $past(dgo_rise))
		else $error("diagnostic tick without edge");
	diag_apart_a: assert property (@(posedge ref_clk)
		disable iff (rst)
		dgo_rise && !sel_rise |=> !main_tick)
		else $error("diagnostic edge reached main path");
endmodule : mcsd_top

// ---- tb/mcsd_host_model.sv ----
// mcsd_host_model: oscillator pins and the optional external clock
// assumes ext_on stays high until a switch back has finished
`timescale 1ns/1ps
module mcsd_host_model (
	input  wire logic ext_on,
	output logic      main_oscillator,
	output logic      ext_clk,
	output logic      diagnostic_oscillator
);
	initial main_oscillator = 1'b0;
	initial ext_clk = 1'b0;
	initial diagnostic_oscillator = 1'b0;
	always #100 main_oscillator = ~main_oscillator;
	always #350 diagnostic_oscillator = ~diagnostic_oscillator;
	// a stopped external clock rests low, as a real idle source would
	always #150 ext_clk = ext_on ? ~ext_clk : 1'b0;
endmodule : mcsd_host_model

// ---- tb/test_mcsd_top.sv ----
// test_mcsd_top: source switching, halving and reset of the clock block
// assumes the oscillator pins are far slower than ref_clk
`timescale 1ns/1ps
`include "mcsd_params.svh"
module test_mcsd_top;
	import mcsd_pkg::*;
	typedef struct {logic sel; mcsd_src_t src; int per;} mcsd_row_t;
	// host model pins toggle every 100 ns and 150 ns
	localparam int OSC_PER = 200 / `MCSD_CLK_PERIOD_NS;
	localparam int EXT_PER = 300 / `MCSD_CLK_PERIOD_NS;
	logic ref_clk = 0, rst = 1, src_sel = 0, ext_on = 0;
	logic main_oscillator, ext_clk, diagnostic_oscillator;
	logic main_tick, modulator_tick, diag_tick, switch_busy;
	logic [`MCSD_SECTIONS-1:0]   section_tick;
	logic [`MCSD_CONVERTERS-1:0] modulator_frequency;
	mcsd_src_t src_active;
	int failures = 0, num_checks = 0, cycles = 0, nm, nd, ng;
	mcsd_row_t rows[3] = '{'{1'h1, MCSD_SRC_EXTERNAL, EXT_PER},
		'{1'h0, MCSD_SRC_INTERNAL, OSC_PER},
		'{1'h1, MCSD_SRC_EXTERNAL, EXT_PER}};
	always #12.5 ref_clk = ~ref_clk;
	mcsd_top mcsd_top_i (.ref_clk(ref_clk), .rst(rst), .src_sel(src_sel),
		.main_oscillator(main_oscillator), .ext_clk(ext_clk),
		.diagnostic_oscillator(diagnostic_oscillator),
		.src_active(src_active), .main_tick(main_tick),
		.section_tick(section_tick), .modulator_tick(modulator_tick),
		.modulator_frequency(modulator_frequency), .diag_tick(diag_tick),
		.switch_busy(switch_busy));
	mcsd_host_model mcsd_host_model_i (.ext_on(ext_on),
		.main_oscillator(main_oscillator), .ext_clk(ext_clk),
		.diagnostic_oscillator(diagnostic_oscillator));
	task automatic check(string what, logic [31:0] exp, logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("wrong value %s exp %0h got %0h", what, exp, got);
		end
	endtask : check
	task automatic wrap_up;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : wrap_up
	// counting over a window avoids guessing the synchroniser phase
	task automatic window(int n, int per);
		bit rate_ok;
		nm = 0;
		nd = 0;
		ng = 0;
		repeat (n) begin
			@(negedge ref_clk);
			nm += main_tick;
			nd += modulator_tick;
			ng += diag_tick;
			check("section", {2{main_tick}}, section_tick);
			check("conv", {3{modulator_frequency[0]}}, modulator_frequency);
		end
		check("halving", 1'b1, (2 * nd - nm) * (2 * nd - nm) <= 1);
		check("diag", 1'b1, ng > 0);
		// per 0 means the source is held back, so no tick may pass
		rate_ok = (per == 0) ? (nm == 0)
			: (nm * per >= n - per && nm * per <= n + per);
		check("rate", 1'h1, rate_ok);
	endtask : window
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles > 20000) begin
			failures++;
			wrap_up();
		end
	end
	initial begin
		repeat (4) @(negedge ref_clk);
		rst = 0;
		check("src", MCSD_SRC_INTERNAL, src_active);
		check("phase", 3'h0, modulator_frequency);
		check("busy", 1'h0, switch_busy);
		window(400, OSC_PER);
		// external clock still stopped: the request must wait
		src_sel = 1'h1;
		window(40, 0);
		check("busy", 1'h1, switch_busy);
		check("src", MCSD_SRC_INTERNAL, src_active);
		ext_on = 1;
		foreach (rows[i]) begin
			// no converter enable reaches this block, so all count as off
			src_sel = rows[i].sel;
			repeat (200) begin
				@(negedge ref_clk);
				if (src_active === rows[i].src && switch_busy === 1'b0)
					break;
			end
			check("src", rows[i].src, src_active);
			check("busy", 1'h0, switch_busy);
			window(400, rows[i].per);
		end
		rst = 1;
		src_sel = 0;
		repeat (3) @(negedge ref_clk);
		check("src", MCSD_SRC_INTERNAL, src_active);
		check("phase", 3'h0, modulator_frequency);
		check("tick", 1'b0, main_tick);
		check("busy", 1'h0, switch_busy);
		rst = 0;
		window(200, OSC_PER);
		wrap_up();
	end
endmodule : test_mcsd_top
